// ### core/ccg_pkg.sv
/*
 * ccg_pkg: register map, field positions, reset values, lane states and
 * timing counts for the card clock output gate.
 * Assumes a 40 MHz pclk and a 12-bit APB byte address.
 */
package ccg_pkg;
	// register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;

	// control register fields
	localparam int CTRL_ICE = 0;
	localparam int CTRL_PLL = 1;
	localparam int CTRL_CCE = 2;
	localparam int CTRL_SLIE = 3;
	localparam int CTRL_DORM = 4;
	localparam int CTRL_DIV_LSB = 16;
	localparam int DIV_W = 10;

	// status register fields
	localparam int STAT_STABLE = 0;
	localparam int STAT_PRESENT = 1;
	localparam int STAT_RUNNING = 2;
	localparam int STAT_DORMANT = 3;
	localparam int STAT_ELECTRICAL_IDLE_STATE = 4;
	localparam int STAT_SYN = 5;
	localparam int STAT_LOGICAL_IDLE_STATE = 6;

	localparam logic [DIV_W-1:0] DIV_RST = 10'h000;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// lane step timing
	localparam int unsigned PCLK_MHZ = 40;
	localparam int unsigned LANE_STEP_NS = 1000;
	localparam int unsigned LANE_STEP_CYC = (LANE_STEP_NS * PCLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		LANE_DORMANT,
		LANE_ELECTRICAL_IDLE_STATE,
		LANE_SYN,
		LANE_LOGICAL_IDLE_STATE
	} ccg_lane_t;
endpackage : ccg_pkg

// ### core/ccg_sync3.sv
/*
 * ccg_sync3: three-stage synchroniser for pin levels.
 * Assumes inputs are asynchronous to pclk; a change is accepted once the
 * second and third stages agree.
 */
`timescale 1ns/1ps
module ccg_sync3 #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] val;
	} ccg_sync_t;

	ccg_sync_t state_r;
	ccg_sync_t state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.ff1 = async_in;
		state_nxt.ff2 = state_r.ff1;
		state_nxt.ff3 = state_r.ff2;
		// hold the old value on any bit where the late stages disagree
		state_nxt.val = (state_r.ff2 & state_r.ff3)
			| (state_r.val & (state_r.ff2 ^ state_r.ff3));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sync_out = state_r.val;
endmodule : ccg_sync3

// ### core/ccg_half_tick.sv
/*
 * ccg_half_tick: half-period enable for the card clock.
 * Assumes run stays high for as long as the clock must toggle; tick pulses
 * once every half_div+1 pclk cycles while run is high.
 */
`timescale 1ns/1ps
module ccg_half_tick #(
	parameter int W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [W-1:0] half_div,
	output logic tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} ccg_tick_t;

	ccg_tick_t state_r;
	ccg_tick_t state_nxt;

	assign tick = run && (state_r.cnt == half_div);

	always_comb begin
		state_nxt = state_r;
		if (!run || tick) begin
			state_nxt.cnt = '0;
		end else begin
			state_nxt.cnt = state_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end
endmodule : ccg_half_tick

// ### core/ccg_gate.sv
/*
 * ccg_gate: card clock output gate with APB register slave.
 * Drives the legacy card bus clock or the serial-lane reference clock,
 * steps lane state out of dormant, and controls PLL power-up.
 * Assumes a 40 MHz pclk, asynchronous card-present and PLL-lock levels,
 * and a zero-wait APB master.
 */
`timescale 1ns/1ps
module ccg_gate #(
	parameter bit HAS_PLL_BIT = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic card_present_pin,
	input wire logic pll_locked,
	output logic pll_power_up,
	output logic core_clock_stable,
	output logic card_bus_clock,
	output logic lane_p_o,
	output logic lane_p_oe,
	output logic lane_n_o,
	output logic lane_n_oe
);
	localparam int DW = ccg_pkg::DIV_W;
	localparam int STEP_BOUND = 41;
	localparam logic [7:0] STEP_LAST = 8'(ccg_pkg::LANE_STEP_CYC - 1);
	localparam int STEP_HOLD = 39;

	typedef struct packed {
		logic ice;
		logic pll_en;
		logic cce;
		logic slie;
		logic [DW-1:0] div_sel;
		logic [DW-1:0] div_act;
		logic clk_level;
		logic [DW-1:0] half_seen;
		logic present_d;
		logic pll_run;
		ccg_pkg::ccg_lane_t lane;
		logic [7:0] step_cnt;
		logic bus_clk;
		logic lp;
		logic ln;
		logic loe;
		logic [31:0] rdata;
	} ccg_state_t;

	ccg_state_t state_r;
	ccg_state_t state_nxt;

	logic [1:0] sync_s;
	logic present_s;
	logic lock_s;
	logic wr;
	logic wr_ctrl;
	logic addr_hit;
	logic stable;
	logic allow;
	logic running;
	logic tick;
	logic step_done;
	logic ref_on;

	ccg_sync3 #(
		.W(2)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({pll_locked, card_present_pin}),
		.sync_out(sync_s)
	);

	assign present_s = sync_s[0];
	assign lock_s = sync_s[1];

	ccg_half_tick #(
		.W(DW)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(running),
		.half_div(state_r.div_act),
		.tick(tick)
	);

	assign addr_hit = (paddr == ccg_pkg::ADDR_CTRL) || (paddr == ccg_pkg::ADDR_STAT);
	assign wr = psel && penable && pwrite;
	assign wr_ctrl = wr && (paddr == ccg_pkg::ADDR_CTRL);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	// lock is only meaningful while the PLL is powered
	assign stable = state_r.ice && (!state_r.pll_run || lock_s);
	// serial lanes must not see a reference clock before lock
	assign allow = state_r.cce && (!state_r.slie || stable);
	// a high clock finishes its half period so the stop lands low
	assign running = allow || state_r.clk_level;
	assign step_done = (state_r.step_cnt == STEP_LAST);

	always_comb begin
		state_nxt = state_r;
		ref_on = 1'b0;
		if (wr_ctrl) begin
			state_nxt.ice = pwdata[ccg_pkg::CTRL_ICE];
			state_nxt.pll_en = pwdata[ccg_pkg::CTRL_PLL];
			state_nxt.cce = pwdata[ccg_pkg::CTRL_CCE];
			state_nxt.slie = pwdata[ccg_pkg::CTRL_SLIE];
			state_nxt.div_sel = pwdata[ccg_pkg::CTRL_DIV_LSB +: DW];
		end
		// removal beats a same-cycle software set: no clock to an empty slot
		state_nxt.present_d = present_s;
		if (state_r.present_d && !present_s) begin
			state_nxt.cce = 1'b0;
		end

		// without a separate PLL bit the legacy PLL follows the enable
		if (!state_nxt.slie && !HAS_PLL_BIT) begin
			state_nxt.pll_run = state_nxt.cce;
		end else begin
			state_nxt.pll_run = state_nxt.pll_en;
		end

		// divider only reloads once the clock has really stopped
		if (!running) begin
			state_nxt.div_act = state_r.div_sel;
		end
		if (tick) begin
			state_nxt.clk_level = !state_r.clk_level;
		end
		// shadow count of the current half period, read only by the assertions
		if (tick || !running) begin
			state_nxt.half_seen = '0;
		end else begin
			state_nxt.half_seen = state_r.half_seen + 1'b1;
		end

		unique case (state_r.lane)
			ccg_pkg::LANE_DORMANT: begin
				// any write with the bit set wakes, even if it already read 1
				if (wr_ctrl && pwdata[ccg_pkg::CTRL_CCE]) begin
					state_nxt.lane = ccg_pkg::LANE_ELECTRICAL_IDLE_STATE;
					state_nxt.step_cnt = '0;
				end
			end
			ccg_pkg::LANE_ELECTRICAL_IDLE_STATE: begin
				if (step_done) begin
					state_nxt.lane = ccg_pkg::LANE_SYN;
					state_nxt.step_cnt = '0;
				end else begin
					state_nxt.step_cnt = state_r.step_cnt + 8'h01;
				end
			end
			ccg_pkg::LANE_SYN: begin
				if (step_done) begin
					state_nxt.lane = ccg_pkg::LANE_LOGICAL_IDLE_STATE;
					state_nxt.step_cnt = '0;
				end else begin
					state_nxt.step_cnt = state_r.step_cnt + 8'h01;
				end
			end
			ccg_pkg::LANE_LOGICAL_IDLE_STATE: begin
				if (wr_ctrl && pwdata[ccg_pkg::CTRL_DORM] && state_r.slie) begin
					state_nxt.lane = ccg_pkg::LANE_DORMANT;
				end
			end
		endcase

		// pin drive follows the next clock level so pins and state agree
		state_nxt.bus_clk = !state_nxt.slie && state_nxt.clk_level;
		ref_on = state_nxt.slie && state_nxt.clk_level;
		if (!state_nxt.slie) begin
			state_nxt.lp = 1'b0;
			state_nxt.ln = 1'b0;
			state_nxt.loe = 1'b0;
		end else if (ref_on || state_nxt.cce) begin
			state_nxt.lp = state_nxt.clk_level;
			state_nxt.ln = !state_nxt.clk_level;
			state_nxt.loe = 1'b1;
		end else begin
			state_nxt.lp = 1'b0;
			state_nxt.ln = 1'b0;
			state_nxt.loe = 1'b1;
		end

		// read data captured in the setup phase for a zero-wait access
		if (psel && !penable) begin
			state_nxt.rdata = ccg_pkg::RDATA_RST;
			if (paddr == ccg_pkg::ADDR_CTRL) begin
				state_nxt.rdata[ccg_pkg::CTRL_ICE] = state_r.ice;
				state_nxt.rdata[ccg_pkg::CTRL_PLL] = state_r.pll_en;
				state_nxt.rdata[ccg_pkg::CTRL_CCE] = state_r.cce;
				state_nxt.rdata[ccg_pkg::CTRL_SLIE] = state_r.slie;
				state_nxt.rdata[ccg_pkg::CTRL_DIV_LSB +: DW] = state_r.div_sel;
			end else if (paddr == ccg_pkg::ADDR_STAT) begin
				state_nxt.rdata[ccg_pkg::STAT_STABLE] = stable;
				state_nxt.rdata[ccg_pkg::STAT_PRESENT] = present_s;
				state_nxt.rdata[ccg_pkg::STAT_RUNNING] = running;
				state_nxt.rdata[ccg_pkg::STAT_DORMANT] =
					(state_r.lane == ccg_pkg::LANE_DORMANT);
				state_nxt.rdata[ccg_pkg::STAT_ELECTRICAL_IDLE_STATE] =
					(state_r.lane == ccg_pkg::LANE_ELECTRICAL_IDLE_STATE);
				state_nxt.rdata[ccg_pkg::STAT_SYN] =
					(state_r.lane == ccg_pkg::LANE_SYN);
				state_nxt.rdata[ccg_pkg::STAT_LOGICAL_IDLE_STATE] =
					(state_r.lane == ccg_pkg::LANE_LOGICAL_IDLE_STATE);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= '0;
			state_r.div_sel <= ccg_pkg::DIV_RST;
			state_r.div_act <= ccg_pkg::DIV_RST;
			state_r.lane <= ccg_pkg::LANE_LOGICAL_IDLE_STATE;
			state_r.rdata <= ccg_pkg::RDATA_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign prdata = state_r.rdata;
	assign pll_power_up = state_r.pll_run;
	assign core_clock_stable = stable;
	assign card_bus_clock = state_r.bus_clk;
	assign lane_p_o = state_r.lp;
	assign lane_n_o = state_r.ln;
	assign lane_p_oe = state_r.loe;
	assign lane_n_oe = state_r.loe;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wake_write;
		(state_r.lane == ccg_pkg::LANE_DORMANT) && wr_ctrl && pwdata[ccg_pkg::CTRL_CCE];
	endsequence

	sequence s_enter_electrical_idle_state;
		$rose(state_r.lane == ccg_pkg::LANE_ELECTRICAL_IDLE_STATE);
	endsequence

	sequence s_dormant_quiet;
		(state_r.lane == ccg_pkg::LANE_DORMANT) && !(wr_ctrl && pwdata[ccg_pkg::CTRL_CCE]);
	endsequence

	sequence s_electrical_idle_state_to_sync;
		##STEP_HOLD (state_r.lane == ccg_pkg::LANE_ELECTRICAL_IDLE_STATE)
		##1 (state_r.lane == ccg_pkg::LANE_SYN);
	endsequence

	a_clock_off_idle: assert property (
		!state_r.cce && !state_r.clk_level |=> !state_r.clk_level && !card_bus_clock)
		else $error("card clock rose while disabled");

	a_divider_frozen: assert property (
		running |=> $stable(state_r.div_act))
		else $error("divider changed while clock running");

	a_stop_low: assert property (
		$fell(running) |-> !state_r.clk_level && !card_bus_clock)
		else $error("clock stopped at high level");

	a_removal_clears: assert property (
		state_r.present_d && !present_s |=> !state_r.cce)
		else $error("enable survived card removal");

	a_legacy_pin: assert property (
		!state_r.slie |-> card_bus_clock == state_r.clk_level && !lane_p_oe)
		else $error("legacy pin does not follow clock");

	// with a separate PLL bit the PLL follows that bit in both modes
	a_pll_start: assert property (
		pll_power_up == ((!state_r.slie && !HAS_PLL_BIT) ? state_r.cce : state_r.pll_en))
		else $error("PLL power does not follow its enable");

	a_ref_locked: assert property (
		state_r.slie && $rose(state_r.clk_level) |-> $past(stable))
		else $error("reference clock before lock");

	a_ref_lanes: assert property (
		state_r.slie && state_r.clk_level |-> lane_p_o && !lane_n_o && lane_p_oe)
		else $error("reference clock not on lanes");

	a_dormant_exit: assert property (
		s_wake_write |=> state_r.lane == ccg_pkg::LANE_ELECTRICAL_IDLE_STATE)
		else $error("wake write did not leave dormant");

	a_lane_sync: assert property (
		s_enter_electrical_idle_state |-> ##[1:STEP_BOUND] state_r.lane == ccg_pkg::LANE_SYN)
		else $error("sync state not reached");

	a_lane_order: assert property (
		$changed(state_r.lane) && state_r.lane == ccg_pkg::LANE_LOGICAL_IDLE_STATE
		|-> $past(state_r.lane) == ccg_pkg::LANE_SYN)
		else $error("logical idle entered out of order");

	a_pull_down: assert property (
		state_r.slie && !state_r.cce && !state_r.clk_level
		|-> lane_p_oe && lane_n_oe && !lane_p_o && !lane_n_o)
		else $error("pull-down missing on reference lines");

	a_half_length: assert property (
		tick |-> state_r.half_seen == state_r.div_act)
		else $error("half period length differs from divider");

	a_ref_wait_lock: assert property (
		state_r.slie && !stable && !state_r.clk_level
		|=> !state_r.clk_level)
		else $error("reference clock rose without lock");

	a_dormant_hold: assert property (
		s_dormant_quiet |=> state_r.lane == ccg_pkg::LANE_DORMANT)
		else $error("dormant left without a wake write");

	a_electrical_idle_state_span: assert property (
		s_enter_electrical_idle_state |-> s_electrical_idle_state_to_sync)
		else $error("electrical idle span wrong");

	a_unmapped_write: assert property (
		wr && !addr_hit && !(state_r.present_d && !present_s)
		|=> $stable(state_r.cce))
		else $error("unmapped write changed the enable");

	a_lock_to_stable: assert property (
		state_r.pll_run && !lock_s |-> !core_clock_stable)
		else $error("stable reported before lock");
endmodule : ccg_gate

// ### testbench/ccg_card_model.sv
/*
 * ccg_card_model: removable card seen from the gate's pins.
 * Assumes the bench pulls the card out by raising pull_out; the reference
 * clock lines carry the card's pull-down termination.
 */
`timescale 1ns/1ps
module ccg_card_model (
	input wire logic pull_out,
	input wire logic lane_p_o,
	input wire logic lane_p_oe,
	input wire logic lane_n_o,
	input wire logic lane_n_oe,
	output logic card_present_pin,
	output logic lane_p,
	output logic lane_n
);
	// function interrupts are never armed here, so none is lost when the clock stops
	assign card_present_pin = !pull_out;
	// released lines settle at the termination level, never the last value
	assign lane_p = lane_p_oe ? lane_p_o : 1'b0;
	assign lane_n = lane_n_oe ? lane_n_o : 1'b0;
endmodule : ccg_card_model

// ### testbench/ccg_gate_tb.sv
/*
 * ccg_gate_tb: self-checking bench for ccg_gate over APB with a card model.
 * Assumes a zero-wait slave and 40-cycle lane steps as the design states.
 */
`timescale 1ns/1ps
module ccg_gate_tb;
	localparam logic [31:0] ICE = 32'h0000_0001 << ccg_pkg::CTRL_ICE;
	localparam logic [31:0] PLL = 32'h0000_0001 << ccg_pkg::CTRL_PLL;
	localparam logic [31:0] CCE = 32'h0000_0001 << ccg_pkg::CTRL_CCE;
	localparam logic [31:0] SLIE = 32'h0000_0001 << ccg_pkg::CTRL_SLIE;
	localparam logic [31:0] DORM = 32'h0000_0001 << ccg_pkg::CTRL_DORM;
	localparam logic [32:0] ALL = 33'h1_ffff_ffff;
	localparam logic [32:0] LANES = 33'h0_0000_0078;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, pll_locked, pull_out;
	logic card_present_pin, pll_power_up, core_clock_stable, card_bus_clock;
	logic lane_p_o, lane_p_oe, lane_n_o, lane_n_oe, lane_p, lane_n, lane_mode, mon;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd, dw;
	logic [32:0] wm;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	int error_cnt = 0;
	int compares = 0;
	assign mon = lane_mode ? lane_p : card_bus_clock;
	ccg_gate #(.HAS_PLL_BIT(1'b1)) ccg_gate_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .card_present_pin(card_present_pin),
		.pll_locked(pll_locked), .pll_power_up(pll_power_up),
		.core_clock_stable(core_clock_stable), .card_bus_clock(card_bus_clock),
		.lane_p_o(lane_p_o), .lane_p_oe(lane_p_oe), .lane_n_o(lane_n_o), .lane_n_oe(lane_n_oe));
	ccg_card_model ccg_card_model_i (.pull_out(pull_out), .lane_p_o(lane_p_o),
		.lane_p_oe(lane_p_oe), .lane_n_o(lane_n_o), .lane_n_oe(lane_n_oe),
		.card_present_pin(card_present_pin), .lane_p(lane_p), .lane_n(lane_n));
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task chk(input string what, input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : chk
	task results;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	task halfp(input int e, input string what);
		logic p;
		int n;
		n = 0;
		p = mon;
		while (mon === p && n < 300) begin
			@(posedge pclk);
			n++;
		end
		p = mon;
		n = 0;
		while (mon === p && n < 300) begin
			@(posedge pclk);
			n++;
		end
		chk(what, 33'(e), 33'(n));
	endtask : halfp
	// the read result is judged at the completing edge, before the slave moves on
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			wm = msk_q.pop_front();
			chk("apb read", exp_q.pop_front(), {pslverr, prdata} & wm);
		end
	end
	initial begin
		#200_000;
		error_cnt++;
		results;
	end
	initial begin
		{psel, penable, pwrite, presetn, pll_locked, pull_out, lane_mode} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		rnd = 32'hcfba_0811;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(ccg_pkg::ADDR_CTRL, 33'h0_0000_0000, ALL);
		rd(ccg_pkg::ADDR_STAT, 33'h0_0000_0042, ALL);
		rd(12'h008, 33'h1_0000_0000, ALL);
		apb(1'b1, 12'h008, 32'hffff_ffff);
		rd(ccg_pkg::ADDR_CTRL, 33'h0_0000_0000, ALL);
		apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL);
		repeat (2) @(posedge pclk);
		chk("pll power and stable", 33'h2, {pll_power_up, core_clock_stable});
		pll_locked <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("stable after lock", 33'h1, core_clock_stable);
		for (int i = 0; i < 2; i++) begin
			rnd = lfsr(rnd);
			dw = {30'h0000_0000, rnd[1:0]} << ccg_pkg::CTRL_DIV_LSB;
			apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | dw);
			apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | CCE | dw);
			halfp(int'(rnd[1:0]) + 1, "legacy half period");
			apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | dw);
			repeat (2 * int'(rnd[1:0]) + 6) @(posedge pclk);
			chk("stopped low", 33'h0, card_bus_clock);
			rd(ccg_pkg::ADDR_STAT, 33'h0_0000_0000, 33'h0_0000_0004);
		end
		apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | CCE);
		pull_out <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(ccg_pkg::ADDR_CTRL, 33'h0_0000_0000, {1'b0, CCE});
		pull_out <= 1'b0;
		pll_locked <= 1'b0;
		lane_mode = 1'b1;
		apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | SLIE);
		repeat (8) @(posedge pclk);
		chk("lane pull-down", 33'hc, {lane_p_oe, lane_n_oe, lane_p, lane_n});
		apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | SLIE | CCE);
		repeat (20) @(posedge pclk);
		chk("held for lock", 33'h0, {lane_p, card_bus_clock});
		pll_locked <= 1'b1;
		halfp(1, "lane half period");
		chk("lane pair", 33'h2, {lane_p ^ lane_n, card_bus_clock});
		apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | SLIE | CCE | DORM);
		rd(ccg_pkg::ADDR_STAT, 33'h0_0000_0008, LANES);
		apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | SLIE | CCE);
		rd(ccg_pkg::ADDR_STAT, 33'h0_0000_0010, LANES);
		repeat (40) @(posedge pclk);
		rd(ccg_pkg::ADDR_STAT, 33'h0_0000_0020, LANES);
		repeat (40) @(posedge pclk);
		rd(ccg_pkg::ADDR_STAT, 33'h0_0000_0040, LANES);
		apb(1'b1, ccg_pkg::ADDR_CTRL, ICE | PLL | SLIE);
		repeat (8) @(posedge pclk);
		chk("lane stop", 33'hc, {lane_p_oe, lane_n_oe, lane_p, lane_n});
		results;
	end
endmodule : ccg_gate_tb
